// file: rtl/led_i2c_defines.vh
// constants for the led driver two-wire slave front end
`ifndef LED_I2C_DEFINES_VH
`define LED_I2C_DEFINES_VH
`define ADDR_DEFAULT      7'h00
`define ADDR_LOW_POS      0
`define ADDR_HIGH_POS     1
`define DIR_READ          1'b1
`define REG_DIGIT0        8'h01
`define REG_DIGIT7        8'h08
`define REG_DECODE        8'h09
`define REG_INTENSITY     8'h0A
`define REG_SCAN_LIMIT    8'h0B
`define REG_SHUTDOWN      8'h0C
`define REG_SELF_ADDR     8'h2D
`define REG_FEATURE       8'h0E
`define REG_TEST          8'h0F
`define SHDN_RUN_BIT      0
`define SHDN_KEEP_BIT     7
`define RST_DECODE        8'h00
`define RST_INTENSITY     8'h00
`define RST_SCAN_LIMIT    8'h00
`define RST_SHUTDOWN      8'h00
`define RST_FEATURE       8'h00
`define RST_TEST          8'h00
`define RST_DIGIT         8'h00
`endif

// file: rtl/led_digit_mem.v
// eight-word digit memory with registered read port
`timescale 1ns/1ps
`default_nettype none
module led_digit_mem (
  input  wire       core_clk_in,
  input  wire       wr_en_in,
  input  wire [2:0] wr_addr_in,
  input  wire [7:0] wr_data_in,
  input  wire [2:0] rd_addr_in,
  output reg  [7:0] rd_data_out
);
  reg [7:0] mem [0:7];  // digit contents, kept through shutdown
  // write and registered read; no reset so contents survive shutdown toggles
  always @(posedge core_clk_in) begin
    if (wr_en_in) begin
      mem[wr_addr_in] <= wr_data_in;
    end
    rd_data_out <= mem[rd_addr_in];
  end
endmodule // led_digit_mem
`default_nettype wire

// file: rtl/led_rx_buffer.v
// two-entry valid/ready buffer for received bytes
`timescale 1ns/1ps
`default_nettype none
module led_rx_buffer (
  input  wire       core_clk_in,
  input  wire       reset_in,
  input  wire       in_valid_in,
  input  wire [8:0] in_data_in,
  output reg        in_ready_out,
  output reg        out_valid_out,
  output reg  [8:0] out_data_out,
  input  wire       out_ready_in
);
  reg [8:0] spare_reg;   // second slot
  reg       spare_v_reg; // second slot holds a word
  wire      take;        // accepted from source
  wire      give;        // consumed by sink
  assign take = in_valid_in & in_ready_out;
  assign give = out_valid_out & out_ready_in;
  // head slot refills from spare first so order is kept
  always @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      out_valid_out <= 1'b0;
      out_data_out  <= 9'h000;
      spare_reg     <= 9'h000;
      spare_v_reg   <= 1'b0;
      in_ready_out  <= 1'b1;
    end else begin
      if (give || !out_valid_out) begin
        if (spare_v_reg) begin
          out_data_out  <= spare_reg;
          out_valid_out <= 1'b1;
          spare_v_reg   <= take;
          spare_reg     <= in_data_in;
          in_ready_out  <= !take;
        end else begin
          out_data_out  <= in_data_in;
          out_valid_out <= take;
          in_ready_out  <= 1'b1;
        end
      end else if (take) begin
        spare_reg    <= in_data_in;
        spare_v_reg  <= 1'b1;
        in_ready_out <= 1'b0; // both slots full: stall source
      end
    end
  end
endmodule // led_rx_buffer
`default_nettype wire

// file: rtl/led_i2c_slave.v
// two-wire bus slave front end and control registers of the led driver
// How it works
// - slave only, never drives clock
// - data change at clock high is control
// - fall is start, rise is stop
// - bytes msb first, ack after each
// - receiver pulls data low through ack
// - master nack ends read, line released
// - write: ack address and every data byte
// - read: shift bytes out on master clock
// - repeated start begins new transfer immediately
// - seven address bits, then direction bit
// - address all zero after power-up
// - two low address bits set by command
// - select bits from two key nodes
// - strap sampling skips key debounce
// - ack only after matching address byte
// - first write byte is command pointer
// - power-up defaults, blanked, in shutdown
// - one digit, no decode, minimum intensity
// - shutdown register write, digits retained
// - shutdown write clears feature unless bit seven
// - shutdown register decodes run and keep bits
// - eight-bit command selects internal register
`timescale 1ns/1ps
`include "led_i2c_defines.vh"
`default_nettype none
module led_i2c_slave (
  input  wire       core_clk_in,
  input  wire       reset_in,
  input  wire       scl_in,
  input  wire       sda_in,
  output reg        sda_out,
  output reg        sda_oe_out,
  input  wire       key_g_node_in,
  input  wire       key_f_node_in,
  output reg        shutdown_out,
  output reg        blank_out,
  output reg  [7:0] decode_out,
  output reg  [7:0] intensity_out,
  output reg  [7:0] scan_limit_out,
  output reg  [7:0] feature_out,
  output reg  [7:0] test_out,
  output reg  [6:0] slave_addr_out,
  output reg        busy_out
);
  // bit phases of the byte engine
  localparam ST_IDLE = 3'd0;
  localparam ST_ADDR = 3'd1;
  localparam ST_AACK = 3'd2;
  localparam ST_WR   = 3'd3;
  localparam ST_WACK = 3'd4;
  localparam ST_RD   = 3'd5;
  localparam ST_RACK = 3'd6;
  localparam ST_SKIP = 3'd7;

  // three-stage synchronisers; stage 1 only feeds stage 2
  reg [2:0] scl_sync_reg;
  reg [2:0] sda_sync_reg;
  reg       scl_reg;        // filtered clock level
  reg       sda_reg;        // filtered data level
  reg [2:0] state_reg;      // transfer phase
  reg [2:0] bit_cnt_reg;    // index of current bit, 7 down to 0
  reg [7:0] shift_reg;      // receive/transmit shifter
  reg       rw_reg;         // direction of this transfer
  reg       cmd_seen_reg;   // pointer already loaded
  reg [7:0] ptr_reg;        // register pointer
  reg       drive_low_reg;  // pull data line low
  reg       pend_rd_reg;    // load next read byte

  // a change counts only when stages two and three agree
  always @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      scl_sync_reg <= 3'h7;
      sda_sync_reg <= 3'h7;
      scl_reg      <= 1'b1;
      sda_reg      <= 1'b1;
    end else begin
      scl_sync_reg <= {scl_sync_reg[1:0], scl_in};
      sda_sync_reg <= {sda_sync_reg[1:0], sda_in};
      if (scl_sync_reg[1] == scl_sync_reg[2]) begin
        scl_reg <= scl_sync_reg[2];
      end
      if (sda_sync_reg[1] == sda_sync_reg[2]) begin
        sda_reg <= sda_sync_reg[2];
      end
    end
  end

  wire scl_now  = (scl_sync_reg[1] == scl_sync_reg[2]) ? scl_sync_reg[2] : scl_reg;
  wire sda_now  = (sda_sync_reg[1] == sda_sync_reg[2]) ? sda_sync_reg[2] : sda_reg;
  wire scl_rise = scl_now & ~scl_reg;
  wire scl_fall = ~scl_now & scl_reg;
  // data moving while clock stays high is a bus condition, not data
  wire start_ev = scl_now & scl_reg & sda_reg & ~sda_now;
  wire stop_ev  = scl_now & scl_reg & ~sda_reg & sda_now;

  // address straps sampled directly, no debounce path
  reg [2:0] key_g_sync_reg;
  reg [2:0] key_f_sync_reg;
  always @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      key_g_sync_reg <= 3'h0;
      key_f_sync_reg <= 3'h0;
    end else begin
      key_g_sync_reg <= {key_g_sync_reg[1:0], key_g_node_in};
      key_f_sync_reg <= {key_f_sync_reg[1:0], key_f_node_in};
    end
  end

  // address compare: upper five fixed, low two from self-addressing
  function addr_match;
    input [6:0] rx;
    input [6:0] own;
    begin
      addr_match = (rx == own);
    end
  endfunction

  // byte-level register write path goes through the two-entry buffer
  reg        wr_valid_reg;  // word offered to buffer
  reg  [8:0] wr_word_reg;   // {is_command, byte}
  wire       buf_ready;
  wire       buf_valid;
  wire [8:0] buf_data;
  wire       buf_take = buf_valid;

  led_rx_buffer u_buf (
    .core_clk_in   (core_clk_in),
    .reset_in      (reset_in),
    .in_valid_in   (wr_valid_reg),
    .in_data_in    (wr_word_reg),
    .in_ready_out  (buf_ready),
    .out_valid_out (buf_valid),
    .out_data_out  (buf_data),
    .out_ready_in  (1'b1)
  );

  // the shifter withholds acks while buffer is full: a full buffer refuses the byte
  wire        dig_wr;
  reg  [7:0]  wr_ptr_reg;   // pointer as seen on the drained side
  wire [7:0]  rd_digit;
  assign dig_wr = buf_take & ~buf_data[8] & (wr_ptr_reg >= `REG_DIGIT0) & (wr_ptr_reg <= `REG_DIGIT7);

  led_digit_mem u_mem (
    .core_clk_in (core_clk_in),
    .wr_en_in    (dig_wr),
    .wr_addr_in  (wr_ptr_reg[2:0] - 3'd1),
    .wr_data_in  (buf_data[7:0]),
    .rd_addr_in  (ptr_reg[2:0] - 3'd1),
    .rd_data_out (rd_digit)
  );

  // read mux for the pointed register
  reg [7:0] rd_byte;
  always @* begin
    case (ptr_reg)
      `REG_DECODE:     rd_byte = decode_out;
      `REG_INTENSITY:  rd_byte = intensity_out;
      `REG_SCAN_LIMIT: rd_byte = scan_limit_out;
      `REG_SHUTDOWN:   rd_byte = {7'h00, ~shutdown_out};
      `REG_FEATURE:    rd_byte = feature_out;
      `REG_TEST:       rd_byte = test_out;
      default:         rd_byte = ((ptr_reg >= `REG_DIGIT0) && (ptr_reg <= `REG_DIGIT7)) ? rd_digit : 8'h00;
    endcase
  end

  // bus protocol engine; only the data line is ever driven
  always @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_reg     <= ST_IDLE;
      bit_cnt_reg   <= 3'd7;
      shift_reg     <= 8'h00;
      rw_reg        <= 1'b0;
      cmd_seen_reg  <= 1'b0;
      ptr_reg       <= 8'h00;
      drive_low_reg <= 1'b0;
      pend_rd_reg   <= 1'b0;
      wr_valid_reg  <= 1'b0;
      wr_word_reg   <= 9'h000;
      busy_out      <= 1'b0;
      sda_out       <= 1'b0;
      sda_oe_out    <= 1'b0;
    end else begin
      if (wr_valid_reg && buf_ready) begin
        wr_valid_reg <= 1'b0;
      end
      if (pend_rd_reg) begin
        shift_reg   <= rd_byte;       // registered digit data now settled
        pend_rd_reg <= 1'b0;
      end
      if (start_ev) begin
        // a repeated start drops whatever phase was running
        state_reg     <= ST_ADDR;
        bit_cnt_reg   <= 3'd7;
        drive_low_reg <= 1'b0;
        cmd_seen_reg  <= 1'b0;
        busy_out      <= 1'b1;
      end else if (stop_ev) begin
        state_reg     <= ST_IDLE;
        drive_low_reg <= 1'b0;
        busy_out      <= 1'b0;
      end else begin
        case (state_reg)
          ST_ADDR, ST_WR: begin
            if (scl_rise) begin
              shift_reg <= {shift_reg[6:0], sda_now}; // msb first
              if (bit_cnt_reg == 3'd0) begin
                state_reg <= (state_reg == ST_ADDR) ? ST_AACK : ST_WACK;
              end else begin
                bit_cnt_reg <= bit_cnt_reg - 3'd1;
              end
            end
          end
          ST_AACK: begin
            if (scl_fall && !drive_low_reg) begin
              // ack only on own address, direction in bit zero
              if (addr_match(shift_reg[7:1], slave_addr_out)) begin
                drive_low_reg <= 1'b1;
                rw_reg        <= shift_reg[0];
                pend_rd_reg   <= (shift_reg[0] == `DIR_READ);
              end else begin
                state_reg <= ST_SKIP;
              end
            end else if (scl_fall && drive_low_reg) begin
              bit_cnt_reg <= 3'd7;
              if (rw_reg == `DIR_READ) begin
                state_reg     <= ST_RD;
                drive_low_reg <= ~shift_reg[7];
              end else begin
                state_reg     <= ST_WR;
                drive_low_reg <= 1'b0;
              end
            end
          end
          ST_WACK: begin
            if (scl_fall && !drive_low_reg) begin
              // a full buffer refuses the byte by withholding ack
              if (!wr_valid_reg) begin
                drive_low_reg <= 1'b1;
                wr_valid_reg  <= 1'b1;
                wr_word_reg   <= {~cmd_seen_reg, shift_reg};
                if (!cmd_seen_reg) begin
                  ptr_reg <= shift_reg;
                end
                cmd_seen_reg  <= 1'b1;
              end else begin
                state_reg <= ST_SKIP;
              end
            end else if (scl_fall && drive_low_reg) begin
              drive_low_reg <= 1'b0;
              bit_cnt_reg   <= 3'd7;
              state_reg     <= ST_WR;
            end
          end
          ST_RD: begin
            if (scl_fall) begin
              if (bit_cnt_reg == 3'd0) begin
                drive_low_reg <= 1'b0;          // release for master ack
                state_reg     <= ST_RACK;
              end else begin
                bit_cnt_reg   <= bit_cnt_reg - 3'd1;
                drive_low_reg <= ~shift_reg[bit_cnt_reg - 3'd1];
              end
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              if (sda_now) begin
                state_reg <= ST_SKIP;           // nack: leave line high
              end else begin
                pend_rd_reg <= 1'b1;            // same register again
              end
            end else if (scl_fall) begin
              bit_cnt_reg   <= 3'd7;
              state_reg     <= ST_RD;
              drive_low_reg <= ~shift_reg[7];
            end
          end
          ST_SKIP: begin
            drive_low_reg <= 1'b0;              // ignore until start or stop
          end
          default: begin
            drive_low_reg <= 1'b0;
          end
        endcase
      end
      // open drain: drive zero only, never the clock line
      sda_out    <= 1'b0;
      sda_oe_out <= drive_low_reg;
    end
  end

  // drained-side register file: applies command and data words in order
  always @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      wr_ptr_reg     <= 8'h00;
      decode_out     <= `RST_DECODE;
      intensity_out  <= `RST_INTENSITY;
      scan_limit_out <= `RST_SCAN_LIMIT;
      feature_out    <= `RST_FEATURE;
      test_out       <= `RST_TEST;
      shutdown_out   <= 1'b1;
      blank_out      <= 1'b1;
      slave_addr_out <= `ADDR_DEFAULT;
    end else if (buf_take) begin
      if (buf_data[8]) begin
        wr_ptr_reg <= buf_data[7:0];
      end else begin
        case (wr_ptr_reg)
          `REG_DECODE:     decode_out     <= buf_data[7:0];
          `REG_INTENSITY:  intensity_out  <= buf_data[7:0];
          `REG_SCAN_LIMIT: scan_limit_out <= buf_data[7:0];
          `REG_TEST:       test_out       <= buf_data[7:0];
          `REG_FEATURE:    feature_out    <= buf_data[7:0];
          `REG_SHUTDOWN: begin
            // digit memory untouched, so toggling flashes the display
            shutdown_out <= ~buf_data[`SHDN_RUN_BIT];
            blank_out    <= ~buf_data[`SHDN_RUN_BIT];
            if (!buf_data[`SHDN_KEEP_BIT]) begin
              feature_out <= `RST_FEATURE;
            end
          end
          `REG_SELF_ADDR: begin
            // straps are fixed wiring; key nodes lose readback use
            slave_addr_out[`ADDR_LOW_POS]  <= key_g_sync_reg[2];
            slave_addr_out[`ADDR_HIGH_POS] <= key_f_sync_reg[2];
          end
          default: begin
            wr_ptr_reg <= wr_ptr_reg;
          end
        endcase
      end
    end
  end
endmodule // led_i2c_slave
`default_nettype wire

// file: tb/led_i2c_slave_asserts.sv
// assertion checker for the led driver two-wire slave front end
`timescale 1ns/1ps
`default_nettype none
module led_i2c_slave_asserts (
  input wire logic       core_clk_in,
  input wire logic       reset_in,
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe_out,
  input wire logic       shutdown_out,
  input wire logic [7:0] feature_out,
  input wire logic [6:0] slave_addr_out,
  input wire logic       busy_out
);
  // one clock domain, so clocking and reset are given once
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (reset_in);

  // open drain: the pin may only ever be pulled low
  AST_DRIVE_LOW_ONLY: assert property (sda_oe_out |-> !sda_out)
    else $error("data pin driven high");
  // the slave moves data only while the clock pin is low
  AST_DATA_MOVES_AT_LOW: assert property ($changed(sda_oe_out) |-> !scl_in)
    else $error("data moved while clock high");
  AST_START_SEEN: assert property ($rose(busy_out) |-> scl_in && !sda_in)
    else $error("busy rose without start");
  AST_STOP_SEEN: assert property ($fell(busy_out) |-> scl_in && sda_in)
    else $error("busy fell without stop");
  // a pull must end within a byte and its acknowledge
  AST_PULL_BOUNDED: assert property ($rose(sda_oe_out) |-> ##[1:200] !sda_oe_out)
    else $error("data pin held low too long");
  AST_PULL_IN_TRANSFER: assert property (sda_oe_out |-> busy_out)
    else $error("data pulled with bus idle");
  AST_ADDR_HIGH_FIXED: assert property (slave_addr_out[6:2] == 5'h00)
    else $error("upper address bits moved");
  AST_ADDR_IDLE_STABLE: assert property (!busy_out |-> $stable(slave_addr_out))
    else $error("address changed with bus idle");
  AST_FEATURE_IN_TRANSFER: assert property ($changed(feature_out) |-> busy_out)
    else $error("feature changed with bus idle");
  AST_SHDN_IN_TRANSFER: assert property ($changed(shutdown_out) |-> busy_out)
    else $error("shutdown changed with bus idle");
endmodule // led_i2c_slave_asserts

bind led_i2c_slave led_i2c_slave_asserts chk_u (
  .core_clk_in    (core_clk_in),
  .reset_in       (reset_in),
  .scl_in         (scl_in),
  .sda_in         (sda_in),
  .sda_out        (sda_out),
  .sda_oe_out     (sda_oe_out),
  .shutdown_out   (shutdown_out),
  .feature_out    (feature_out),
  .slave_addr_out (slave_addr_out),
  .busy_out       (busy_out)
);
`default_nettype wire

// file: tb/i2c_master_model.sv
// behavioural two-wire bus master that clocks the slave
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model (
  input  wire logic core_clk_in,
  input  wire logic sda_in,      // resolved data line
  output var  logic scl_out,     // bus clock, stands high between frames
  output var  logic sda_low_out  // high while the master pulls data low
);
  initial begin
    scl_out     = 1'b1;
    sda_low_out = 1'b0;
  end
  // one quarter of the 80 ns bus clock period
  task automatic quarter(input int n);
    repeat (4 * n) @(posedge core_clk_in);
  endtask
  // data falls while clock high; also serves as repeated start
  task automatic bus_start();
    sda_low_out <= 1'b0;
    quarter(1);
    scl_out <= 1'b1;
    quarter(1);
    sda_low_out <= 1'b1;
    quarter(2);
    scl_out <= 1'b0;
    quarter(1);
  endtask
  // data rises while clock high, then the bus idles
  task automatic bus_stop();
    sda_low_out <= 1'b1;
    quarter(1);
    scl_out <= 1'b1;
    quarter(1);
    sda_low_out <= 1'b0;
    quarter(4);
  endtask
  // data set in the low phase and held through the high phase
  task automatic put_bit(input logic b);
    sda_low_out <= !b;
    quarter(1);
    scl_out <= 1'b1;
    quarter(2);
    scl_out <= 1'b0;
    quarter(1);
  endtask
  task automatic get_bit(output logic b);
    sda_low_out <= 1'b0;
    quarter(1);
    scl_out <= 1'b1;
    quarter(1);
    b = sda_in;
    quarter(1);
    scl_out <= 1'b0;
    quarter(1);
  endtask
  task automatic write_byte(input logic [7:0] b, output logic ack);
    logic seen;
    for (int i = 7; i >= 0; i--) put_bit(b[i]);
    get_bit(seen);
    ack = !seen; // low means acknowledged
  endtask
  // acknowledge every byte except the last one
  task automatic read_byte(input logic last, output logic [7:0] b);
    for (int i = 7; i >= 0; i--) get_bit(b[i]);
    put_bit(last);
  endtask
endmodule // i2c_master_model
`default_nettype wire

// file: tb/led_i2c_slave_tb.sv
// self-checking bench for the led driver two-wire slave
`timescale 1ns/1ps
`default_nettype none
module led_i2c_slave_tb;
  logic            core_clk_in;
  logic            reset_in;
  logic            key_g_node_in;
  logic            key_f_node_in;
  wire logic       scl_line;
  wire logic       sda_line;
  wire logic       mst_low;
  wire logic       sda_out, sda_oe_out, shutdown_out, blank_out, busy_out;
  wire logic [7:0] decode_out, intensity_out, scan_limit_out, feature_out, test_out;
  wire logic [6:0] slave_addr_out;
  int              fail_count;
  int              checks_done;

  // pull-up: the line is low only while someone pulls it
  assign sda_line = (mst_low || (sda_oe_out && !sda_out)) ? 1'b0 : 1'b1;

  initial core_clk_in = 1'b0;
  always #2.5 core_clk_in = ~core_clk_in;

  led_i2c_slave dut_u (
    .core_clk_in(core_clk_in), .reset_in(reset_in), .scl_in(scl_line), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe_out(sda_oe_out), .key_g_node_in(key_g_node_in),
    .key_f_node_in(key_f_node_in), .shutdown_out(shutdown_out), .blank_out(blank_out),
    .decode_out(decode_out), .intensity_out(intensity_out), .scan_limit_out(scan_limit_out),
    .feature_out(feature_out), .test_out(test_out), .slave_addr_out(slave_addr_out),
    .busy_out(busy_out));
  i2c_master_model mst_u (
    .core_clk_in(core_clk_in), .sda_in(sda_line), .scl_out(scl_line), .sda_low_out(mst_low));

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // address, command and one data byte, every one acknowledged
  task automatic wr_reg(input logic [6:0] a, input logic [7:0] cmd, input logic [7:0] d);
    logic k;
    mst_u.bus_start();
    mst_u.write_byte({a, 1'b0}, k);
    check("address ack", {7'h00, k}, 8'h01);
    mst_u.write_byte(cmd, k);
    check("command ack", {7'h00, k}, 8'h01);
    mst_u.write_byte(d, k);
    check("data ack", {7'h00, k}, 8'h01);
    mst_u.bus_stop();
  endtask

  task automatic t_defaults();
    check("shutdown", {7'h00, shutdown_out}, 8'h01);
    check("blank", {7'h00, blank_out}, 8'h01);
    check("decode", decode_out, 8'h00);
    check("intensity", intensity_out, 8'h00);
    check("scan limit", scan_limit_out, 8'h00);
    check("address", {1'b0, slave_addr_out}, 8'h00);
  endtask

  task automatic t_control_writes();
    wr_reg(7'h00, 8'h09, 8'hA5);
    wr_reg(7'h00, 8'h0A, 8'h05);
    wr_reg(7'h00, 8'h0B, 8'h07);
    wr_reg(7'h00, 8'h0F, 8'h01);
    wr_reg(7'h00, 8'h01, 8'h3C);
    check("decode", decode_out, 8'hA5);
    check("intensity", intensity_out, 8'h05);
    check("scan limit", scan_limit_out, 8'h07);
    check("test", test_out, 8'h01);
  endtask

  // all four run/keep bit combinations, each one entering or leaving shutdown
  task automatic t_shutdown();
    logic [7:0] codes [4] = '{8'h81, 8'h80, 8'h01, 8'h00}; // first code keeps bit seven set
    foreach (codes[i]) begin
      wr_reg(7'h00, 8'h0E, 8'h0F);
      wr_reg(7'h00, 8'h0C, codes[i]);
      check("shutdown", {7'h00, shutdown_out}, {7'h00, !codes[i][0]});
      check("blank", {7'h00, blank_out}, {7'h00, !codes[i][0]});
      check("feature", feature_out, codes[i][7] ? 8'h0F : 8'h00);
    end
  endtask

  // pointer write, repeated start, two reads of the digit
  task automatic t_read();
    logic       k;
    logic [7:0] b;
    mst_u.bus_start();
    mst_u.write_byte(8'h00, k);
    mst_u.write_byte(8'h01, k);
    check("pointer ack", {7'h00, k}, 8'h01);
    mst_u.bus_start();
    check("busy held", {7'h00, busy_out}, 8'h01);
    mst_u.write_byte(8'h01, k);
    check("read address ack", {7'h00, k}, 8'h01);
    mst_u.read_byte(1'b0, b);
    check("first read", b, 8'h3C);
    mst_u.read_byte(1'b1, b);
    check("last read", b, 8'h3C);
    check("released", {7'h00, sda_oe_out}, 8'h00);
    mst_u.bus_stop();
    check("idle", {7'h00, busy_out}, 8'h00);
  endtask

  // a foreign address is never acknowledged
  task automatic t_wrong_addr(input logic [7:0] a);
    logic k;
    mst_u.bus_start();
    mst_u.write_byte(a, k);
    check("foreign address", {7'h00, k}, 8'h00);
    mst_u.write_byte(8'h0A, k);
    check("ignored byte", {7'h00, k}, 8'h00);
    mst_u.write_byte(8'h0F, k);
    check("ignored data", {7'h00, k}, 8'h00);
    mst_u.bus_stop();
    // a wrongly taken transfer would have stored 0x0F here
    check("intensity kept", intensity_out, 8'h05);
  endtask

  // straps give the two low address bits
  task automatic t_self_addr();
    wr_reg(7'h00, 8'h2D, 8'h00);
    check("self address", {1'b0, slave_addr_out}, 8'h02);
    t_wrong_addr(8'h00);
    wr_reg(7'h02, 8'h0A, 8'h03);
    check("new address write", intensity_out, 8'h03);
  endtask

  // a second power-up restores defaults; the master must self-address again
  task automatic t_reset();
    reset_in <= 1'b1;
    repeat (4) @(posedge core_clk_in);
    reset_in <= 1'b0;
    repeat (4) @(posedge core_clk_in);
    t_defaults();
    wr_reg(7'h00, 8'h2D, 8'h00);
    check("readdressed", {1'b0, slave_addr_out}, 8'h02);
  endtask

  initial begin
    reset_in      <= 1'b1;
    key_g_node_in <= 1'b0;
    key_f_node_in <= 1'b1;
    repeat (4) @(posedge core_clk_in);
    reset_in <= 1'b0;
    repeat (4) @(posedge core_clk_in);
    t_defaults();
    t_control_writes();
    t_shutdown();
    t_read();
    t_wrong_addr(8'h22);
    t_self_addr();
    t_reset();
    close_out();
  end

  // watchdog: the sequence needs about 47 us, so four times that is a hang
  initial begin
    #200000;
    fail_count++;
    close_out();
  end
endmodule // led_i2c_slave_tb
`default_nettype wire
